// [logic/pifd_pkg.sv]
/*
 * Shared constants, format codes and lane packing for the pixel input
 * format demultiplexer link (graphics controller end and capture end).
 * Assumes both ends import this package and meet over pifd_if.
 */
// Notes on behaviour
// - 5:6:5 RGB: green/blue falling, red/green rising
// - 4:2:2 double edge: Cb, Y0, Cr, Y1
// - 656 style: one byte per rising edge only
// - index byte from lines 7..0, falling edge
// - index mode ignores upper lines and rising edge
// - alternate 4:4:4 uses scrambled 24-bit lane order
// - edge and slot bits set capture order, except in 656 and index
package pifd_pkg;

    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int PIFD_DW        = 12;   // pixel data lines
    localparam int PIFD_CW        = 8;    // component width
    localparam int PIFD_CLK_NS    = 40;   // system clock period
    localparam int PIFD_LINK_NS   = 160;  // link period made by the host
    localparam int PIFD_LINK_DIV  = PIFD_LINK_NS / PIFD_CLK_NS;
    localparam int PIFD_SETTLE_PERIODS = 3; // idle periods after reset
    localparam logic [PIFD_DW-1:0] PIFD_DATA_RESET = 12'h000;
    localparam logic [PIFD_CW-1:0] PIFD_COMP_RESET = 8'h00;

    // ****************************************************************
    // format codes and 656 byte sequence
    // ****************************************************************
    typedef enum logic [2:0] {
        PIFD_FMT_RGB565  = 3'h1,
        PIFD_FMT_YCC422  = 3'h3,
        PIFD_FMT_SER656  = 3'h4,
        PIFD_FMT_INDEX   = 3'h5,
        PIFD_FMT_RGB888A = 3'h6
    } pifd_fmt_t;

    typedef enum logic [1:0] {
        PIFD_SEQ_CB = 2'h0,
        PIFD_SEQ_Y0 = 2'h1,
        PIFD_SEQ_CR = 2'h2,
        PIFD_SEQ_Y1 = 2'h3
    } pifd_seq_t;

    typedef struct packed {
        logic [PIFD_DW-1:0] fall_col;  // content of the falling column
        logic [PIFD_DW-1:0] rise_col;  // content of the rising column
    } pifd_cols_t;

endpackage : pifd_pkg

// [logic/pifd_if.sv]
/*
 * Link between the graphics controller (host) and the capture end
 * (device): pixel clock plus twelve data lines, both driven by host.
 * Assumes the testbench instantiates it and joins the two ends.
 */
interface pifd_if;
    logic        pix_clk;        // link clock, made by the host
    logic [11:0] pixel_data_in;  // double-edge pixel data

    modport host   (output pix_clk, output pixel_data_in);
    modport device (input  pix_clk, input  pixel_data_in);
endinterface : pifd_if

// [logic/pifd_device.sv]
/*
 * Capture end: samples pixel_data_in on both edges of the link clock,
 * pairs the samples, splits them into colour components per format
 * and hands each pixel to the clk domain with a toggle crossing.
 * Assumes the host keeps data stable around each link clock edge and
 * that config inputs change only while no pixels are wanted.
 */
module pifd_device
    import pifd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [2:0]        fmt_sel,
    input  wire logic              edge_first_fall,
    input  wire logic              slot_swap,
    pifd_if.device                 link,
    output logic                   out_valid,
    output logic [PIFD_CW-1:0]     out_red,
    output logic [PIFD_CW-1:0]     out_green,
    output logic [PIFD_CW-1:0]     out_blue,
    output logic [PIFD_CW-1:0]     out_index
);

    // ****************************************************************
    // link domain reset and configuration crossing
    // ****************************************************************
    logic                lk_rst_meta;
    logic                lk_rst;
    logic [4:0]          cfg_s1;
    logic [4:0]          cfg_s2;
    logic [4:0]          cfg_s3;
    logic [4:0]          cfg;
    logic [2:0]          lk_fmt;
    logic                lk_edge;
    logic                lk_slot;

    // assert at once, release on the link clock; link may stall so the
    // release waits for two real edges
    always_ff @(posedge link.pix_clk or posedge reset) begin
        if (reset) begin
            lk_rst_meta <= 1'b1;
            lk_rst      <= 1'b1;
        end else begin
            lk_rst_meta <= 1'b0;
            lk_rst      <= lk_rst_meta;
        end
    end

    // three-stage capture; a change counts once stages two and three agree
    always_ff @(posedge link.pix_clk or posedge lk_rst) begin
        if (lk_rst) begin
            cfg_s1 <= 5'h00;
            cfg_s2 <= 5'h00;
            cfg_s3 <= 5'h00;
            cfg    <= 5'h00;   // no format: silent until the setting crosses
        end else begin
            cfg_s1 <= {fmt_sel, edge_first_fall, slot_swap};
            cfg_s2 <= cfg_s1;
            cfg_s3 <= cfg_s2;
            if (cfg_s2 == cfg_s3) begin
                cfg <= cfg_s3;
            end
        end
    end

    assign lk_fmt  = cfg[4:2];
    assign lk_edge = cfg[1];
    assign lk_slot = cfg[0];

    // ****************************************************************
    // edge sampling and pairing
    // ****************************************************************
    logic [PIFD_DW-1:0]  fall_smp;
    logic [PIFD_DW-1:0]  rise_smp;
    logic [PIFD_DW-1:0]  first_w;
    logic [PIFD_DW-1:0]  second_w;
    pifd_cols_t          cols;

    // falling-edge word, held for the next rising edge
    always_ff @(negedge link.pix_clk or posedge lk_rst) begin
        if (lk_rst) begin
            fall_smp <= PIFD_DATA_RESET;
        end else begin
            fall_smp <= link.pixel_data_in;
        end
    end

    // rising-edge word, needed when the rising edge comes first
    always_ff @(posedge link.pix_clk or posedge lk_rst) begin
        if (lk_rst) begin
            rise_smp <= PIFD_DATA_RESET;
        end else begin
            rise_smp <= link.pixel_data_in;
        end
    end

    // pair completes at a rising edge in both orders, so one decode
    // domain serves both settings
    always_comb begin
        if (lk_edge) begin
            first_w  = fall_smp;
            second_w = link.pixel_data_in;
        end else begin
            first_w  = rise_smp;
            second_w = fall_smp;
        end
        // slot clear: first word holds the falling column
        cols.fall_col = lk_slot ? second_w : first_w;
        cols.rise_col = lk_slot ? first_w  : second_w;
    end

    // ****************************************************************
    // format decode
    // ****************************************************************
    pifd_seq_t           seq;
    pifd_seq_t           next_seq;
    logic                ph;
    logic [PIFD_CW-1:0]  lk_r;
    logic [PIFD_CW-1:0]  lk_g;
    logic [PIFD_CW-1:0]  lk_b;
    logic [PIFD_CW-1:0]  lk_i;
    logic [PIFD_CW-1:0]  next_r;
    logic [PIFD_CW-1:0]  next_g;
    logic [PIFD_CW-1:0]  next_b;
    logic [PIFD_CW-1:0]  next_i;
    logic                emit;
    logic                lk_tog;
    logic [7:0]          pin_byte;

    assign pin_byte = link.pixel_data_in[7:0];

    // one layout at a time; short components are msb aligned
    always_comb begin
        next_r   = lk_r;
        next_g   = lk_g;
        next_b   = lk_b;
        next_i   = lk_i;
        next_seq = pifd_seq_t'(seq + 2'h1);             // free running
        emit     = 1'b0;
        case (lk_fmt)
            PIFD_FMT_RGB565: begin
                next_r = {cols.rise_col[7:3], 3'h0};
                next_g = {cols.rise_col[2:0], cols.fall_col[7:5], 2'h0};
                next_b = {cols.fall_col[4:0], 3'h0};
                emit   = 1'b1;
            end
            PIFD_FMT_YCC422: begin
                next_g = cols.rise_col[7:0];
                if (ph) begin
                    next_r = cols.fall_col[7:0];
                end else begin
                    next_b = cols.fall_col[7:0];
                end
                emit = 1'b1;
            end
            PIFD_FMT_SER656: begin
                case (seq)
                    PIFD_SEQ_CB: next_b = pin_byte;
                    PIFD_SEQ_CR: next_r = pin_byte;
                    default:     next_g = pin_byte;
                endcase
                emit = seq[0];
            end
            PIFD_FMT_INDEX: begin
                // upper lines and the rising word are never looked at
                next_i = fall_smp[7:0];
                emit   = 1'b1;
            end
            PIFD_FMT_RGB888A: begin
                next_r = {cols.rise_col[11:7], cols.rise_col[3:1]};
                next_g = {cols.rise_col[6:4], cols.fall_col[11:9],
                          cols.rise_col[0], cols.fall_col[3]};
                next_b = {cols.fall_col[8:4], cols.fall_col[2:0]};
                emit   = 1'b1;
            end
            default: begin
                emit = 1'b0;
            end
        endcase
    end

    // component registers and the event toggle for the crossing
    always_ff @(posedge link.pix_clk or posedge lk_rst) begin
        if (lk_rst) begin
            lk_r   <= PIFD_COMP_RESET;
            lk_g   <= PIFD_COMP_RESET;
            lk_b   <= PIFD_COMP_RESET;
            lk_i   <= PIFD_COMP_RESET;
            lk_tog <= 1'b0;
        end else begin
            lk_r <= next_r;
            lk_g <= next_g;
            lk_b <= next_b;
            lk_i <= next_i;
            if (emit) begin
                lk_tog <= ~lk_tog;
            end
        end
    end

    // byte and period phase; no in-band sync, so both run on every
    // rising edge from the link reset whatever the format: that ties them
    // to the host count however late the format setting crosses. the
    // host's first byte rides the second edge after the reset lifts,
    // hence the byte count starts one step behind
    always_ff @(posedge link.pix_clk or posedge lk_rst) begin
        if (lk_rst) begin
            seq <= PIFD_SEQ_Y1;
            ph  <= 1'b0;
        end else begin
            seq <= next_seq;
            ph  <= ~ph;
        end
    end

    // ****************************************************************
    // crossing into the clk domain
    // ****************************************************************
    logic                tog_s1;
    logic                tog_s2;
    logic                tog_s3;

    // data is held a full link period (four clk) after each toggle, so
    // it is stable when the synchronised toggle is seen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= lk_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // output registers, one-cycle valid per pixel
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_red   <= PIFD_COMP_RESET;
            out_green <= PIFD_COMP_RESET;
            out_blue  <= PIFD_COMP_RESET;
            out_index <= PIFD_COMP_RESET;
        end else begin
            out_valid <= tog_s2 ^ tog_s3;
            if (tog_s2 ^ tog_s3) begin
                out_red   <= lk_r;
                out_green <= lk_g;
                out_blue  <= lk_b;
                out_index <= lk_i;
            end
        end
    end

endmodule : pifd_device

// [logic/pifd_host.sv]
/*
 * Graphics controller end: divides clk by four to make the link clock,
 * takes one pixel per link period over valid/ready (in 656, one per two periods) and drives the two
 * edge words in the order set by the edge and slot inputs, an order fixed for 656 and index.
 * Assumes the device samples on both edges of the link clock.
 */
module pifd_host
    import pifd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [2:0]        fmt_sel,
    input  wire logic              edge_first_fall,
    input  wire logic              slot_swap,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [PIFD_CW-1:0] in_red,
    input  wire logic [PIFD_CW-1:0] in_green,
    input  wire logic [PIFD_CW-1:0] in_blue,
    input  wire logic [PIFD_CW-1:0] in_index,
    pifd_if.host                   link
);

    // ****************************************************************
    // link clock divider and start-up settle
    // ****************************************************************
    logic [1:0]          ph;
    logic [1:0]          settle;
    logic                settled;
    logic                take;
    pifd_seq_t           seq;

    assign settled = (settle == 2'(PIFD_SETTLE_PERIODS));
    assign take    = (ph == 2'h0) && in_ready && in_valid;

    // link clock high in phases 2 and 3; words change mid low/high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ph           <= 2'h0;
            link.pix_clk <= 1'b0;
        end else begin
            ph           <= ph + 2'h1;
            link.pix_clk <= (ph == 2'h1) || (ph == 2'h2);
        end
    end

    // idle periods let the device leave reset before data counts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settle <= 2'h0;
            seq    <= PIFD_SEQ_CB;
        end else if (ph == 2'h0) begin
            if (!settled) begin
                settle <= settle + 2'h1;
            end else begin
                seq <= pifd_seq_t'(seq + 2'h1);
            end
        end
    end

    // ready for the phase-0 cycle; 656 takes a pixel every other byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_ready <= 1'b0;
        end else begin
            in_ready <= (ph == 2'h3) && settled &&
                        ((fmt_sel != PIFD_FMT_SER656) || !seq[0]);
        end
    end

    // ****************************************************************
    // pixel hold and lane packing
    // ****************************************************************
    logic [PIFD_CW-1:0]  h_r;
    logic [PIFD_CW-1:0]  h_g;
    logic [PIFD_CW-1:0]  h_b;
    logic [PIFD_CW-1:0]  h_i;
    logic [PIFD_CW-1:0]  p_r;
    logic [PIFD_CW-1:0]  p_g;
    logic [PIFD_CW-1:0]  p_b;
    logic [PIFD_CW-1:0]  p_i;
    pifd_cols_t          cols;
    logic                eff_edge;
    logic                eff_slot;
    logic [PIFD_DW-1:0]  first_w;
    logic [PIFD_DW-1:0]  second_w;
    logic [PIFD_DW-1:0]  w_first;
    logic [PIFD_DW-1:0]  w_second;

    // without a new pixel the last one is repeated
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            h_r <= PIFD_COMP_RESET;
            h_g <= PIFD_COMP_RESET;
            h_b <= PIFD_COMP_RESET;
            h_i <= PIFD_COMP_RESET;
        end else if (take) begin
            h_r <= in_red;
            h_g <= in_green;
            h_b <= in_blue;
            h_i <= in_index;
        end
    end

    assign p_r = take ? in_red   : h_r;
    assign p_g = take ? in_green : h_g;
    assign p_b = take ? in_blue  : h_b;
    assign p_i = take ? in_index : h_i;

    // column contents per format; unused lines driven low
    always_comb begin
        cols     = '0;
        eff_edge = edge_first_fall;
        eff_slot = slot_swap;
        case (fmt_sel)
            PIFD_FMT_RGB565: begin
                cols.fall_col = {4'h0, p_g[4:2], p_b[7:3]};
                cols.rise_col = {4'h0, p_r[7:3], p_g[7:5]};
            end
            PIFD_FMT_YCC422: begin
                cols.fall_col = {4'h0, seq[0] ? p_r : p_b};
                cols.rise_col = {4'h0, p_g};
            end
            PIFD_FMT_SER656: begin
                case (seq)
                    PIFD_SEQ_CB: cols.rise_col = {4'h0, p_b};
                    PIFD_SEQ_CR: cols.rise_col = {4'h0, p_r};
                    default:     cols.rise_col = {4'h0, p_g};
                endcase
                eff_edge = 1'b0;   // rising column lands on the rising edge
                eff_slot = 1'b1;
            end
            PIFD_FMT_INDEX: begin
                cols.fall_col = {4'h0, p_i};
                eff_edge = 1'b0;   // falling column lands on falling edge
                eff_slot = 1'b1;
            end
            PIFD_FMT_RGB888A: begin
                cols.fall_col = {p_g[4:2], p_b[7:3], p_g[0], p_b[2:0]};
                cols.rise_col = {p_r[7:3], p_g[7:5], p_r[2:0], p_g[1]};
            end
            default: begin
                cols = '0;
            end
        endcase
        first_w  = eff_slot ? cols.rise_col : cols.fall_col;
        second_w = eff_slot ? cols.fall_col : cols.rise_col;
    end

    // ****************************************************************
    // word sequencing on the data lines
    // ****************************************************************
    // phase 0 feeds the rising edge, phase 2 the falling edge; with the
    // falling edge first, the rising word closes the previous pair
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            w_first            <= PIFD_DATA_RESET;
            w_second           <= PIFD_DATA_RESET;
            link.pixel_data_in <= PIFD_DATA_RESET;
        end else if (ph == 2'h0) begin
            w_first            <= first_w;
            w_second           <= second_w;
            link.pixel_data_in <= eff_edge ? w_second : first_w;
        end else if (ph == 2'h2) begin
            link.pixel_data_in <= eff_edge ? w_first : w_second;
        end
    end

endmodule : pifd_host

// [tb/pifd_properties.sv]
/*
 * Checker for the pixel link: clock shape, data hold around each
 * link clock edge, pixel and request spacing, silent unknown formats.
 * Assumes the link clock is made from clk and fmt changes in reset.
 */
module pifd_properties
    import pifd_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic [2:0]        fmt_sel,
    input wire logic              pix_clk,
    input wire logic [PIFD_DW-1:0] pixel_data_in,
    input wire logic              in_ready,
    input wire logic              out_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // assertions, all in the clk domain
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // link clock is clk divided by four, two high and two low
    a_link_clk_shape: assert property (
        $rose(pix_clk) |=> pix_clk ##1 !pix_clk [*2] ##1 pix_clk)
        else $error("link clock shape wrong");
    // data must stand across each sampling edge; the edge is seen one
    // clk late, so the cycle that ends there is the one around the edge
    a_rise_data_hold: assert property (
        $rose(pix_clk) |-> $stable(pixel_data_in))
        else $error("data moved at rising edge");
    a_fall_data_hold: assert property (
        $fell(pix_clk) |-> $stable(pixel_data_in))
        else $error("data moved at falling edge");
    a_pixel_gap: assert property (
        out_valid |=> !out_valid [*3])
        else $error("pixels closer than a link period");
    a_ready_gap: assert property (
        in_ready |=> !in_ready [*3])
        else $error("requests closer than a link period");
    // one byte a period in 656 mode: one pixel per two periods
    a_ser_pixel_gap: assert property (
        (fmt_sel == PIFD_FMT_SER656) && out_valid |=> !out_valid [*7])
        else $error("656 pixels too close");
    a_ser_ready_gap: assert property (
        (fmt_sel == PIFD_FMT_SER656) && in_ready |=> !in_ready [*7])
        else $error("656 requests too close");
    a_bad_fmt_quiet: assert property (
        !(fmt_sel inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h6}) |-> !out_valid)
        else $error("pixel emitted for unknown format");

    c_index_pixel: cover property (out_valid && fmt_sel == PIFD_FMT_INDEX);
    c_ser_pixel:   cover property (out_valid && fmt_sel == PIFD_FMT_SER656);
    c_rgb_pixel:   cover property (out_valid && fmt_sel == PIFD_FMT_RGB565);
endmodule : pifd_properties

// [tb/pixel_input_format_demux_test.sv]
/*
 * Testbench joining host and capture end over pifd_if: offers one
 * pixel, lets the link repeat it, then checks the wire and outputs.
 * Assumes config is only changed while both ends are held in reset.
 */
module pixel_input_format_demux_test;
    import pifd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk, reset, edge_first_fall, slot_swap;
    logic [2:0]        fmt_sel;
    logic              in_valid, in_ready, out_valid;
    logic [7:0]        in_red, in_green, in_blue, in_index;
    logic [7:0]        out_red, out_green, out_blue, out_index;
    int                error_cnt, num_checks, cycle_cnt, pulse_cnt;

    pifd_if link_if ();
    pifd_host i_pifd_host (.clk(clk), .reset(reset), .fmt_sel(fmt_sel),
        .edge_first_fall(edge_first_fall), .slot_swap(slot_swap),
        .in_valid(in_valid), .in_ready(in_ready), .in_red(in_red),
        .in_green(in_green), .in_blue(in_blue), .in_index(in_index),
        .link(link_if));
    pifd_device i_pifd_device (.clk(clk), .reset(reset), .fmt_sel(fmt_sel),
        .edge_first_fall(edge_first_fall), .slot_swap(slot_swap),
        .link(link_if), .out_valid(out_valid), .out_red(out_red),
        .out_green(out_green), .out_blue(out_blue), .out_index(out_index));
    pifd_properties i_pifd_properties (.clk(clk), .reset(reset),
        .fmt_sel(fmt_sel), .pix_clk(link_if.pix_clk),
        .pixel_data_in(link_if.pixel_data_in), .in_ready(in_ready),
        .out_valid(out_valid));

    // ************************************************************
    // clock, pulse counter, hang guard
    // ************************************************************
    always #20 clk = ~clk;

    // counts device pixels since the last take; the hang guard sits
    // here so a stuck handshake still reaches the verdict
    always @(posedge clk) begin
        cycle_cnt++;
        if (out_valid === 1'b1) pulse_cnt++;
        if (cycle_cnt == 6000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // ************************************************************
    // expected lane packing
    // ************************************************************
    function automatic pifd_cols_t exp_cols(input logic [2:0] f,
        input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
        input logic [7:0] x);
        pifd_cols_t c;
        c = '0;
        case (f)
            PIFD_FMT_RGB565: begin
                c.fall_col = {4'h0, g[4:2], b[7:3]};
                c.rise_col = {4'h0, r[7:3], g[7:5]};
            end
            PIFD_FMT_RGB888A: begin
                c.fall_col = {g[4:2], b[7:3], g[0], b[2:0]};
                c.rise_col = {r[7:3], g[7:5], r[2:0], g[1]};
            end
            default: c.fall_col = {4'h0, x};
        endcase
        return c;
    endfunction : exp_cols

    // one pixel, then idle so the link repeats it: that keeps the
    // check free of the unsynced 4:2:2 and 656 phase
    task automatic send(input logic [7:0] r, input logic [7:0] g,
        input logic [7:0] b, input logic [7:0] x);
        pifd_cols_t c;
        logic [11:0] m;
        logic        f;
        int          n;
        c = exp_cols(fmt_sel, r, g, b, x);
        m = (fmt_sel == PIFD_FMT_RGB888A) ? 12'hFFF : 12'h0FF;
        f = edge_first_fall ^ slot_swap;
        in_red <= r;
        in_green <= g;
        in_blue <= b;
        in_index <= x;
        in_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (in_ready !== 1'b1 && n < 40);
        in_valid <= 1'b0;
        pulse_cnt = 0;
        check(n < 40, 1'b1);
        repeat (24) @(posedge clk);
        check(pulse_cnt != 0, 1'b1);
        case (fmt_sel)
            PIFD_FMT_INDEX: begin
                check(out_index, x);
                @(negedge link_if.pix_clk);
                check(link_if.pixel_data_in & m, c.fall_col);
            end
            PIFD_FMT_RGB565: begin
                check(out_red, r & 8'hF8);
                check(out_green, g & 8'hFC);
                check(out_blue, b & 8'hF8);
            end
            default: begin
                check(out_red, r);
                check(out_green, g);
                check(out_blue, b);
            end
        endcase
        if (fmt_sel inside {PIFD_FMT_RGB565, PIFD_FMT_RGB888A}) begin
            @(negedge link_if.pix_clk);
            check(link_if.pixel_data_in & m,
                  f ? c.fall_col : c.rise_col);
            @(posedge link_if.pix_clk);
            check(link_if.pixel_data_in & m,
                  f ? c.rise_col : c.fall_col);
        end
    endtask : send

    // config is set in reset, but its crossing only starts once the link
    // reset lifts, so pixels wait; n of zero probes a refused format
    task automatic run_cfg(input logic [2:0] f, input logic e,
        input logic s, input int n);
        reset <= 1'b1;
        fmt_sel <= f;
        edge_first_fall <= e;
        slot_swap <= s;
        in_valid <= 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (8 * PIFD_LINK_DIV) @(posedge clk);
        if (n == 0) begin
            in_valid <= 1'b1;
            pulse_cnt = 0;
            repeat (60) @(posedge clk);
            in_valid <= 1'b0;
            check(12'(pulse_cnt), 12'h000);
        end
        for (int i = 0; i < n; i++) begin
            if (i == 0) send(8'hFF, 8'hFF, 8'hFF, 8'hFF);
            else if (i == 1) send(8'h00, 8'h00, 8'h00, 8'h00);
            else send(8'($urandom()), 8'($urandom()), 8'($urandom()),
                      8'($urandom()));
        end
    endtask : run_cfg

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        fmt_sel = 3'h0;
        edge_first_fall = 1'b0;
        slot_swap = 1'b0;
        in_valid = 1'b0;
        in_red = 8'h00;
        in_green = 8'h00;
        in_blue = 8'h00;
        in_index = 8'h00;
        error_cnt = 0;
        num_checks = 0;
        cycle_cnt = 0;
        pulse_cnt = 0;
        void'($urandom(68403));
        for (int e = 0; e < 4; e++) begin
            run_cfg(PIFD_FMT_RGB565, e[0], e[1], 3);
            run_cfg(PIFD_FMT_RGB888A, e[0], e[1], 3);
        end
        run_cfg(PIFD_FMT_YCC422, 1'b0, 1'b0, 4);
        run_cfg(PIFD_FMT_SER656, 1'b1, 1'b1, 4);
        run_cfg(PIFD_FMT_INDEX, 1'b1, 1'b0, 4);
        run_cfg(3'h0, 1'b0, 1'b0, 0);
        run_cfg(3'h2, 1'b0, 1'b0, 0);
        run_cfg(3'h7, 1'b0, 1'b0, 0);
        finish_test();
    end
endmodule : pixel_input_format_demux_test
